// ===== inc/mqe_pkg.sv
/*
 Shared constants, state encoding and the quadrature decode function for the
 magnetic quadrature encoder output block.
 Assumes a 10 MHz clock and an interpolator that reports position in quarter steps.
*/
// Functional notes
// - One pole pair is 160 steps, shown as 40 full quadrature cycles.
// - A and B are a quarter cycle apart; A leads forward, B leads reverse.
// - Index appears once per pole pair, once every 40 quadrature cycles.
// - Index is high at the reference step and drops one step away.
// - While index is high at the index position, A and B are both high.
// - Low or missing field shows as index high with A and B low.
// - Step hysteresis between one and two steps stops boundary chatter.
// - Output changes after 0.5 to 1.5 steps of movement; no step skipped.
// - Outputs stay disabled until amplitude valid, interpolator locked and field present; at 500 us they enable showing the warning.
package mqe_pkg;

    // --------------------------------------------------------------
    // Geometry
    // --------------------------------------------------------------
    localparam int unsigned STEPS_PER_PAIR = 160;
    localparam int unsigned QUAD_PER_PAIR  = 40;
    localparam int unsigned STEP_W         = 8;
    localparam int unsigned POS_W          = 10;
    localparam int unsigned DIFF_W         = 11;
    localparam logic [POS_W-1:0] POS_SPAN  = 10'h280;
    localparam logic [STEP_W-1:0] STEP_LAST = 8'h9f;
    localparam logic [STEP_W-1:0] STEP_ZERO = 8'h00;
    localparam logic [STEP_W-1:0] INDEX_STEP = 8'h00;
    localparam logic [1:0]  STEP_CENTER_Q  = 2'h2;
    localparam logic [1:0]  PHASE_OFFSET   = 2'h2;

    // --------------------------------------------------------------
    // Hysteresis in quarter steps from the centre of the held step
    // --------------------------------------------------------------
    localparam logic signed [DIFF_W-1:0] HYST_THR_Q = 11'sh005;
    localparam logic signed [DIFF_W-1:0] HALF_SPAN  = 11'sh140;

    // --------------------------------------------------------------
    // Timing
    // --------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned PWRUP_US      = 500;
    localparam int unsigned PWRUP_CYC     = (PWRUP_US * 1000) / CLK_PERIOD_NS;
    localparam int unsigned TMR_W         = 13;
    localparam int unsigned SYNC_N        = 3;

    // --------------------------------------------------------------
    // Output state machine
    // --------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_PWRUP = 3'h1,
        ST_RUN   = 3'h2,
        ST_WARN  = 3'h4
    } mqe_state_e;

    // Quadrature levels {a, b} of a step
    function automatic logic [1:0] quad_ab(input logic [STEP_W-1:0] step);
        logic [1:0] p;
        p = step[1:0] + PHASE_OFFSET;
        return {p[1] ^ p[0], p[1]};
    endfunction

endpackage

// ===== inc/mqe_step_if.sv
/*
 Carries the held step and its index flag from the tracker to the pin logic, and the track enable back.
 Assumes both ends run on the same clock.
*/
`timescale 1ns/100ps
interface mqe_step_if;
    logic [mqe_pkg::STEP_W-1:0] step;
    logic                       at_index;
    logic                       track;

    modport tracker (output step, output at_index, input track);
    modport user    (input step, input at_index, output track);
endinterface

// ===== logic/mqe_step_tracker.sv
/*
 Step tracker: follows the interpolated position with hysteresis, one step per clock.
 Assumes pos arrives on clk with a valid strobe, in quarter steps 0..639.
*/
`timescale 1ns/100ps
module mqe_step_tracker (
    input  wire logic                       clk,
    input  wire logic                       rst,
    input  wire logic [mqe_pkg::POS_W-1:0]  pos,
    input  wire logic                       pos_valid,
    mqe_step_if.tracker                     sif
);

    logic [mqe_pkg::STEP_W-1:0] step_q;
    logic [mqe_pkg::STEP_W-1:0] step_d;
    logic signed [mqe_pkg::DIFF_W-1:0] diff;
    logic [mqe_pkg::POS_W-1:0]  center;

    // ------------------------------------------------------------
    // Next step
    // ------------------------------------------------------------
    always_comb begin
        center = {step_q, mqe_pkg::STEP_CENTER_Q};
        diff   = $signed({1'b0, pos}) - $signed({1'b0, center});
        if (diff >= mqe_pkg::HALF_SPAN) begin
            diff = diff - $signed({1'b0, mqe_pkg::POS_SPAN});
        end else if (diff < -mqe_pkg::HALF_SPAN) begin
            diff = diff + $signed({1'b0, mqe_pkg::POS_SPAN});
        end
        step_d = step_q;
        if (pos_valid && sif.track && pos < mqe_pkg::POS_SPAN) begin
            // Band of 1.25 steps each side gives 1.5 steps of hysteresis
            if (diff > mqe_pkg::HYST_THR_Q) begin
                step_d = (step_q == mqe_pkg::STEP_LAST) ? mqe_pkg::STEP_ZERO
                                                        : step_q + 8'h01;
            end else if (diff < -mqe_pkg::HYST_THR_Q) begin
                step_d = (step_q == mqe_pkg::STEP_ZERO) ? mqe_pkg::STEP_LAST
                                                        : step_q - 8'h01;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            step_q <= mqe_pkg::STEP_ZERO;
        end else begin
            step_q <= step_d;
        end
    end

    assign sif.step     = step_q;
    assign sif.at_index = (step_q == mqe_pkg::INDEX_STEP);

endmodule

// ===== logic/mqe_encoder_out.sv
/*
 Top of the encoder output logic: input synchronisers, power-up gating,
 field warning and the registered A, B and index pins.
 Assumes analog status levels arrive asynchronously and position on clk.
*/
`timescale 1ns/100ps
module mqe_encoder_out #(
    parameter int unsigned PWRUP_CYCLES = mqe_pkg::PWRUP_CYC
) (
    input  wire logic                       clk,
    input  wire logic                       rst,
    input  wire logic [mqe_pkg::POS_W-1:0]  pos,
    input  wire logic                       pos_valid,
    input  wire logic                       amp_valid_raw,
    input  wire logic                       locked_raw,
    input  wire logic                       field_low_raw,
    output logic                            quad_a,
    output logic                            quad_b,
    output logic                            index,
    output logic                            out_oe_n,
    output logic                            outputs_live
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    mqe_step_if sif ();

    logic [mqe_pkg::SYNC_N-1:0] raw_in;
    logic [mqe_pkg::SYNC_N-1:0] sync1_q;
    logic [mqe_pkg::SYNC_N-1:0] sync1_d;
    logic [mqe_pkg::SYNC_N-1:0] sync2_q;
    logic [mqe_pkg::SYNC_N-1:0] sync2_d;

    logic amp_ok;
    logic locked;
    logic field_low;
    logic healthy;

    mqe_pkg::mqe_state_e state_q;
    mqe_pkg::mqe_state_e state_d;

    logic [mqe_pkg::TMR_W-1:0] tmr_q;
    logic [mqe_pkg::TMR_W-1:0] tmr_d;
    logic                      tmr_done;

    logic a_q;
    logic a_d;
    logic b_q;
    logic b_d;
    logic idx_q;
    logic idx_d;
    logic oe_n_q;
    logic oe_n_d;
    logic live_q;
    logic live_d;
    logic [1:0] ab;

    // ------------------------------------------------------------
    // Step tracker
    // ------------------------------------------------------------
    mqe_step_tracker u_tracker (
        .clk       (clk),
        .rst       (rst),
        .pos       (pos),
        .pos_valid (pos_valid),
        .sif       (sif.tracker)
    );

    // Tracker follows position except in ST_WARN (field, amplitude or lock bad)
    assign sif.track = (state_q != mqe_pkg::ST_WARN);

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    assign raw_in = {field_low_raw, locked_raw, amp_valid_raw};

    // Two flops per status level; only the second one is read
    genvar gi;
    generate
        for (gi = 0; gi < mqe_pkg::SYNC_N; gi++) begin : g_sync
            always_comb begin
                sync1_d[gi] = raw_in[gi];
                sync2_d[gi] = sync1_q[gi];
            end
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (rst) begin
            sync1_q <= 3'h0;
            sync2_q <= 3'h0;
        end else begin
            sync1_q <= sync1_d;
            sync2_q <= sync2_d;
        end
    end

    assign amp_ok    = sync2_q[0];
    assign locked    = sync2_q[1];
    assign field_low = sync2_q[2];
    assign healthy   = amp_ok && locked && !field_low;

    // ------------------------------------------------------------
    // Power-up timer
    // ------------------------------------------------------------
    // Counts in power-up only and stops at its limit
    always_comb begin
        tmr_d    = tmr_q;
        tmr_done = (32'(tmr_q) >= PWRUP_CYCLES - 1);
        if (state_q == mqe_pkg::ST_PWRUP && !tmr_done) begin
            tmr_d = tmr_q + 13'h0001;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            tmr_q <= 13'h0000;
        end else begin
            tmr_q <= tmr_d;
        end
    end

    // ------------------------------------------------------------
    // State machine
    // ------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        case (state_q)
            mqe_pkg::ST_PWRUP: begin
                // Give up waiting at the power-up limit and report the field
                if (healthy) begin
                    state_d = mqe_pkg::ST_RUN;
                end else if (tmr_done) begin
                    state_d = mqe_pkg::ST_WARN;
                end
            end
            mqe_pkg::ST_RUN: begin
                // Loss of amplitude, lock or field all show as the warning
                if (!healthy) begin
                    state_d = mqe_pkg::ST_WARN;
                end
            end
            mqe_pkg::ST_WARN: begin
                // Tracker frozen here; it walks one step per clock on exit
                if (healthy) begin
                    state_d = mqe_pkg::ST_RUN;
                end
            end
            default: begin
                state_d = mqe_pkg::ST_PWRUP;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= mqe_pkg::ST_PWRUP;
        end else begin
            state_q <= state_d;
        end
    end

    // ------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------
    // Pins use state_d so they switch on the same edge as the state
    always_comb begin
        ab     = mqe_pkg::quad_ab(sif.step);
        a_d    = 1'b0;
        b_d    = 1'b0;
        idx_d  = 1'b0;
        oe_n_d = 1'b1;
        live_d = 1'b0;
        case (state_d)
            mqe_pkg::ST_PWRUP: begin
                oe_n_d = 1'b1;
            end
            mqe_pkg::ST_RUN: begin
                oe_n_d = 1'b0;
                live_d = 1'b1;
                a_d    = ab[1];
                b_d    = ab[0];
                // Index step decodes to A=B=1
                idx_d  = sif.at_index;
            end
            mqe_pkg::ST_WARN: begin
                oe_n_d = 1'b0;
                live_d = 1'b1;
                idx_d  = 1'b1;
                a_d    = 1'b0;
                b_d    = 1'b0;
            end
            default: begin
                oe_n_d = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            a_q    <= 1'b0;
            b_q    <= 1'b0;
            idx_q  <= 1'b0;
            oe_n_q <= 1'b1;
            live_q <= 1'b0;
        end else begin
            a_q    <= a_d;
            b_q    <= b_d;
            idx_q  <= idx_d;
            oe_n_q <= oe_n_d;
            live_q <= live_d;
        end
    end

    assign quad_a       = a_q;
    assign quad_b       = b_q;
    assign index        = idx_q;
    assign out_oe_n     = oe_n_q;
    assign outputs_live = live_q;

endmodule

// ===== verification/mqe_encoder_out_props.sv
/*
 Checker for the encoder output pins.
 Assumes binding to mqe_encoder_out, one clock, synchronous reset.
*/
`timescale 1ns/100ps
module mqe_encoder_out_props #(
    parameter int unsigned PWRUP_CYCLES = 20
) (
    input wire logic                      clk,
    input wire logic                      rst,
    input wire logic [mqe_pkg::POS_W-1:0] pos,
    input wire logic                      pos_valid,
    input wire logic                      amp_valid_raw,
    input wire logic                      locked_raw,
    input wire logic                      field_low_raw,
    input wire logic                      quad_a,
    input wire logic                      quad_b,
    input wire logic                      index,
    input wire logic                      out_oe_n,
    input wire logic                      outputs_live
);
    int unsigned wait_q;
    int unsigned wait_d;
    always_comb begin
        wait_d = (rst || outputs_live) ? 0 : wait_q + 1;
    end
    always_ff @(posedge clk) begin
        wait_q <= wait_d;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    chk_oe_live_pair: assert property (out_oe_n == !outputs_live)
        else $error("enable and live flag disagree");
    chk_off_pins_low: assert property (out_oe_n |-> !quad_a && !quad_b && !index)
        else $error("pins not low while disabled");
    chk_pwrup_bound: assert property (wait_q <= PWRUP_CYCLES + 4)
        else $error("pins still disabled after power-up time");
    chk_no_redisable: assert property (!$rose(out_oe_n))
        else $error("pins disabled again");
    chk_index_pair: assert property (index |-> quad_a == quad_b)
        else $error("index with unequal channels");
    chk_warn_code: assert property ($rose(field_low_raw) && outputs_live
        |-> ##[1:4] (index && !quad_a && !quad_b)) else $error("no field warning");
    chk_warn_clears: assert property ($fell(field_low_raw) && amp_valid_raw && locked_raw
        |-> ##[1:4] (!index || quad_a)) else $error("warning does not clear");
    chk_one_channel: assert property (outputs_live && $past(outputs_live) && !index
        && !$past(index) |-> !($changed(quad_a) && $changed(quad_b)))
        else $error("both channels changed at once");
    cov_live: cover property ($rose(outputs_live));
    cov_index: cover property (index && quad_a && quad_b);
    cov_warn: cover property (index && !quad_a && outputs_live);
endmodule
bind mqe_encoder_out mqe_encoder_out_props #(.PWRUP_CYCLES(PWRUP_CYCLES)) i_mqe_encoder_out_props (
    .clk(clk), .rst(rst), .pos(pos), .pos_valid(pos_valid), .amp_valid_raw(amp_valid_raw),
    .locked_raw(locked_raw), .field_low_raw(field_low_raw), .quad_a(quad_a), .quad_b(quad_b),
    .index(index), .out_oe_n(out_oe_n), .outputs_live(outputs_live));

// ===== verification/mqe_counter_model.sv
/*
 Model of the external quadrature counter: steps, index and warning counts.
 Assumes pins registered on the same clock.
*/
`timescale 1ns/100ps
module mqe_counter_model (
    input  wire logic clk,
    input  wire logic quad_a,
    input  wire logic quad_b,
    input  wire logic index,
    input  wire logic out_oe_n,
    output int        steps,
    output int        idx_cnt,
    output int        warn_cnt
);
    logic [1:0] prev_q;
    logic       idx_q;
    logic       warn_q;
    logic       warn_now;
    logic       idx_now;
    assign warn_now = !out_oe_n && index && !quad_a && !quad_b;
    assign idx_now  = !out_oe_n && index && quad_a && quad_b;
    // Gray code to phase number
    function automatic int code(input logic [1:0] ab);
        return ab[1] ? (ab[0] ? 0 : 3) : (ab[0] ? 1 : 2);
    endfunction
    initial begin
        steps = 0;
        idx_cnt = 0;
        warn_cnt = 0;
        prev_q = 2'h3;
        idx_q = 1'b0;
        warn_q = 1'b0;
    end
    always @(posedge clk) begin
        if (warn_now && !warn_q) warn_cnt++;
        if (idx_now && !idx_q) idx_cnt++;
        if (!out_oe_n && !warn_now) begin
            if (((code({quad_a, quad_b}) - code(prev_q)) & 3) == 1) steps++;
            else if (((code({quad_a, quad_b}) - code(prev_q)) & 3) == 3) steps--;
            prev_q <= {quad_a, quad_b};
        end
        warn_q <= warn_now;
        idx_q <= idx_now;
    end
endmodule

// ===== verification/magnetic_quadrature_encoder_out_bench.sv
/*
 Testbench for the encoder output block with a counter model on its pins.
 Assumes a short power-up parameter for simulation.
*/
`timescale 1ns/100ps
module magnetic_quadrature_encoder_out_bench;
    localparam int unsigned PWRUP_N = 20;
    logic                      clk, rst, pos_valid, amp_valid_raw, locked_raw, field_low_raw;
    logic [mqe_pkg::POS_W-1:0] pos;
    logic                      quad_a, quad_b, index, out_oe_n, outputs_live;
    int                        steps, idx_cnt, warn_cnt, fail_count, checks, cyc, base;
    mqe_encoder_out #(.PWRUP_CYCLES(PWRUP_N)) i_mqe_encoder_out (
        .clk(clk), .rst(rst), .pos(pos), .pos_valid(pos_valid), .amp_valid_raw(amp_valid_raw),
        .locked_raw(locked_raw), .field_low_raw(field_low_raw), .quad_a(quad_a),
        .quad_b(quad_b), .index(index), .out_oe_n(out_oe_n), .outputs_live(outputs_live));
    mqe_counter_model i_mqe_counter_model (.clk(clk), .quad_a(quad_a), .quad_b(quad_b),
        .index(index), .out_oe_n(out_oe_n), .steps(steps), .idx_cnt(idx_cnt),
        .warn_cnt(warn_cnt));
    // ----------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: saw %0h want %0h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #10;
    endtask
    function automatic logic [1:0] exp_ab(input int s);
        logic [1:0] t[4];
        t = '{2'h3, 2'h1, 2'h0, 2'h2};
        return t[s % 4];
    endfunction
    task automatic summarize();
        if (fail_count == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // ----------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------
    task automatic t_pwrup();
        tick(2);
        check({out_oe_n, outputs_live}, 2'h2);
        tick(PWRUP_N + 4);
        check({out_oe_n, outputs_live}, 2'h1);
        check({index, quad_a, quad_b}, 3'h4);
        amp_valid_raw = 1'b1;
        locked_raw = 1'b1;
        tick(5);
        check({index, quad_a, quad_b}, 3'h7);
    endtask
    task automatic t_hyst();
        pos = 10'h008;
        tick(1);
        check({index, quad_a, quad_b}, 3'h7);
        tick(1);
        check({index, quad_a, quad_b}, 3'h1);
        pos = 10'h001;
        tick(3);
        check({index, quad_a, quad_b}, 3'h1);
        pos = 10'h000;
        tick(3);
        check({index, quad_a, quad_b}, 3'h7);
    endtask
    task automatic t_sweep();
        base = idx_cnt;
        for (int s = 1; s <= 160; s++) begin
            pos = 10'((4 * s + 4) % 640);
            tick(3);
            check({quad_a, quad_b}, exp_ab(s));
            check(index, s == 160);
        end
        check(steps, 160);
        check(idx_cnt, base + 1);
        for (int s = 159; s >= 0; s--) begin
            pos = 10'(4 * s);
            tick(3);
            check({quad_a, quad_b}, exp_ab(s));
            check(index, s == 0);
        end
        check(steps, 0);
        check(idx_cnt, base + 2);
    endtask
    task automatic t_warn();
        field_low_raw = 1'b1;
        tick(5);
        check({index, quad_a, quad_b}, 3'h4);
        check(warn_cnt, 2);
        field_low_raw = 1'b0;
        tick(5);
        check({index, quad_a, quad_b}, 3'h7);
        check(steps, 0);
        locked_raw = 1'b0;
        tick(5);
        check({index, quad_a, quad_b}, 3'h4);
        check(warn_cnt, 3);
        locked_raw = 1'b1;
        tick(5);
        check({index, quad_a, quad_b}, 3'h7);
    endtask
    task automatic t_reset();
        rst = 1'b1;
        tick(2);
        check({out_oe_n, outputs_live, index}, 3'h4);
        rst = 1'b0;
        tick(1);
        check({out_oe_n, outputs_live}, 2'h2);
        tick(2);
        check({out_oe_n, index, quad_a, quad_b}, 4'h7);
    endtask
    // ----------------------------------------------------------
    // Clock, timeout and main sequence
    // ----------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            fail_count++;
            summarize();
        end
    end
    initial begin
        rst = 1'b1;
        pos = 10'h002;
        pos_valid = 1'b1;
        amp_valid_raw = 1'b0;
        locked_raw = 1'b0;
        field_low_raw = 1'b0;
        tick(8);
        rst = 1'b0;
        t_pwrup();
        t_hyst();
        t_sweep();
        t_warn();
        t_reset();
        summarize();
    end
endmodule
